// ==== hcsd_pkg.sv ====
// Purpose: Shared constants and types of the high-speed conditioner strap and flag logic
// Assumes: mclk at 10 MHz
// Notes: Chirp bounds are converted to cycle counts here
//
// Summary of operation
// - The AC boost select level is captured once, right after reset release, and later changes are ignored.
// - Changes on the AC boost select pin during operation have no effect; the latched setting stays.
// - The AC boost select input decodes to one of four boost settings.
// - A floating AC boost select pin at reset release selects the maximum AC boost.
// - Outside I2C mode the shared level_a pin is read at reset as a three-level Level_a strap.
// - Level_a decode: pin high gives 80 mV, floating gives 60 mV, low gives 40 mV.
// - In I2C mode the level_a pin is neither sampled as a strap nor driven with the flag.
// - After reset, outside I2C mode, the level_a pin becomes the output of the high-speed-mode flag.
// - The flag rises after a test fixture is seen from the unconnected state and a test packet follows.
// - The flag rises on squelch detection after a bus reset that ended in a good high-speed handshake.
// - A good handshake is one chirp J followed by one chirp K, each lasting 18 us to 128 us.
// - While the reset pin is low the block stays in reset and runs only when it is high.
// - I2C mode is chosen only when both I2C lines are pulled up at reset, otherwise strap mode.
// - In strap mode the connect-detect flag rises on a pull-up seen while unconnected and falls on disconnect.
package hcsd_pkg;

    localparam int CLK_HZ = 10_000_000;
    localparam int CHIRP_MIN_NS = 18_000;
    localparam int CHIRP_MAX_NS = 128_000;
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
    // Least time rounds up, longest time rounds down
    localparam int CHIRP_MIN_CYC = (CHIRP_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int CHIRP_MAX_CYC = CHIRP_MAX_NS / CLK_NS;
    localparam int CHIRP_CNT_W = $clog2(CHIRP_MAX_CYC + 2);

    // Cycles after release before synchronised straps are valid
    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    localparam logic [1:0] AC_BOOST_MAX = 2'h3;

    // Bit positions in the synchronised input vector
    localparam int SYNC_W = 15;
    localparam int B_ACL = 0;
    localparam int B_ACH = 1;
    localparam int B_ACOPEN = 2;
    localparam int B_LAIN = 3;
    localparam int B_LAOPEN = 4;
    localparam int B_SDA = 5;
    localparam int B_SCL = 6;
    localparam int B_PULLUP = 7;
    localparam int B_DISC = 8;
    localparam int B_BUSRST = 9;
    localparam int B_SQUELCH = 10;
    localparam int B_CHIRPJ = 11;
    localparam int B_CHIRPK = 12;
    localparam int B_FIXTURE = 13;
    localparam int B_TESTPKT = 14;
    localparam logic [SYNC_W-1:0] SYNC_RST = 15'h0000;

    typedef enum logic [1:0] {
        LEVEL_A_40MV = 2'b00,
        LEVEL_A_60MV = 2'b01,
        LEVEL_A_80MV = 2'b10
    } hcsd_level_a_t;

    typedef enum logic [2:0] {
        LNK_UNCONN = 3'b000,
        LNK_FIXTURE = 3'b001,
        LNK_CONN = 3'b010,
        LNK_HSHAKE = 3'b011,
        LNK_SQWAIT = 3'b100,
        LNK_HS = 3'b101
    } hcsd_link_t;

    typedef enum logic [1:0] {
        CHP_IDLE = 2'b00,
        CHP_J = 2'b01,
        CHP_K = 2'b10
    } hcsd_chirp_t;

endpackage

// ==== hcsd_chirp_if.sv ====
// Purpose: Carrier between the link controller and the chirp timer
// Assumes: Same clock on both sides
// Notes: pass and fail are one-cycle pulses
`timescale 1ns/1ps
interface hcsd_chirp_if;
    logic start;
    logic abort;
    logic chirpJ;
    logic chirpK;
    logic pass;
    logic fail;

    modport ctrl (output start, output abort, output chirpJ, output chirpK, input pass, input fail);
    modport timer (input start, input abort, input chirpJ, input chirpK, output pass, output fail);
endinterface

// ==== hcsd_chirp_timer.sv ====
// Purpose: Times one chirp J then one chirp K and judges the pair
// Assumes: Chirp levels already synchronised to mclk
// Notes: A chirp longer than the upper bound fails at once
`timescale 1ns/1ps
module hcsd_chirp_timer #(
    parameter int MIN_CYC = hcsd_pkg::CHIRP_MIN_CYC,
    parameter int MAX_CYC = hcsd_pkg::CHIRP_MAX_CYC,
    parameter int CNT_W = hcsd_pkg::CHIRP_CNT_W
) (
    input wire logic mclk,
    input wire logic arst_n,
    hcsd_chirp_if.timer chp
);
    import hcsd_pkg::*;

    localparam logic [CNT_W-1:0] MIN_C = CNT_W'(MIN_CYC);
    localparam logic [CNT_W-1:0] MAX_C = CNT_W'(MAX_CYC);
    localparam logic [CNT_W-1:0] ONE_C = CNT_W'(1);

    hcsd_chirp_t state, next_state;
    logic [CNT_W-1:0] count, next_count;
    logic pass, next_pass;
    logic fail, next_fail;

    logic inRange;
    assign inRange = (count >= MIN_C) && (count <= MAX_C);

    always_comb begin
        next_state = state;
        next_count = count;
        next_pass = 1'b0;
        next_fail = 1'b0;
        unique case (state)
            CHP_IDLE: begin
                next_count = '0;
                if (chp.start) begin
                    next_state = CHP_J;
                end
            end
            CHP_J: begin
                if (chp.chirpJ) begin
                    next_count = count + ONE_C;
                    if (count > MAX_C) begin
                        next_state = CHP_IDLE;
                        next_fail = 1'b1;
                    end
                end else if (count != '0) begin
                    next_count = '0;
                    if (inRange) begin
                        next_state = CHP_K;
                    end else begin
                        next_state = CHP_IDLE;
                        next_fail = 1'b1;
                    end
                end
            end
            CHP_K: begin
                if (chp.chirpK) begin
                    next_count = count + ONE_C;
                    if (count > MAX_C) begin
                        next_state = CHP_IDLE;
                        next_fail = 1'b1;
                    end
                end else if (count != '0) begin
                    next_state = CHP_IDLE;
                    next_pass = inRange;
                    next_fail = !inRange;
                end
            end
            default: begin
                next_state = CHP_IDLE;
            end
        endcase
        if (chp.abort) begin
            next_state = CHP_IDLE;
            next_pass = 1'b0;
            next_fail = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= CHP_IDLE;
            count <= '0;
            pass <= 1'b0;
            fail <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            pass <= next_pass;
            fail <= next_fail;
        end
    end

    assign chp.pass = pass;
    assign chp.fail = fail;
endmodule // hcsd_chirp_timer

// ==== hcsd_strap_detect.sv ====
// Purpose: Strap capture, mode choice and high-speed / connect flags of the conditioner
// Assumes: Line events come from analog detectors as levels, asynchronous to mclk
// Notes: arst_n is the device reset pin itself
`timescale 1ns/1ps
module hcsd_strap_detect (
    input wire logic mclk,
    input wire logic arst_n,
    // AC boost select sense: resistor code and open-pin detect
    input wire logic [1:0] acBoostCode,
    input wire logic acBoostOpen,
    // Shared level_a pin
    input wire logic levelAIn,
    input wire logic levelAOpen,
    output logic levelAOut,
    output logic levelAOe,
    // I2C lines sensed for mode, SCL doubles as connect-detect output
    input wire logic sdaIn,
    input wire logic sclIn,
    output logic connectDetectOut,
    output logic connectDetectOe,
    // Line events
    input wire logic pullupSeen,
    input wire logic disconnectSeen,
    input wire logic busResetSeen,
    input wire logic squelchSeen,
    input wire logic chirpJSeen,
    input wire logic chirpKSeen,
    input wire logic fixtureSeen,
    input wire logic testPacketSeen,
    // Configuration results
    output logic [1:0] acBoostSetting,
    output hcsd_pkg::hcsd_level_a_t dcBoostSetting,
    output logic i2cMode,
    output logic strapDone,
    output logic hsModeFlag,
    output logic connectDetectFlag
);
    import hcsd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [SYNC_W-1:0] syncRaw;
    logic [SYNC_W-1:0] syncMeta;
    logic [SYNC_W-1:0] syncIn;

    assign syncRaw = {testPacketSeen, fixtureSeen, chirpKSeen, chirpJSeen, squelchSeen, busResetSeen,
                      disconnectSeen, pullupSeen, sclIn, sdaIn, levelAOpen, levelAIn, acBoostOpen,
                      acBoostCode[1], acBoostCode[0]};

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            syncMeta <= SYNC_RST;
            syncIn <= SYNC_RST;
        end else begin
            syncMeta <= syncRaw;
            syncIn <= syncMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Strap senses after synchronisation
    logic [1:0] acCodeSync;
    logic acOpenSync;
    logic levelAHigh;
    logic levelAFloat;
    logic sdaUp;
    logic sclUp;
    logic i2cLinesUp;

    assign acCodeSync = {syncIn[B_ACH], syncIn[B_ACL]};
    assign acOpenSync = syncIn[B_ACOPEN];
    assign levelAHigh = syncIn[B_LAIN];
    assign levelAFloat = syncIn[B_LAOPEN];
    assign sdaUp = syncIn[B_SDA];
    assign sclUp = syncIn[B_SCL];
    assign i2cLinesUp = sdaUp && sclUp;

    ////////////////////////////////////////////////////////////////////////////////
    // Strap decode
    logic [1:0] acDecoded;
    hcsd_level_a_t dcDecoded;

    always_comb begin
        acDecoded = acCodeSync;
        if (acOpenSync) begin
            acDecoded = AC_BOOST_MAX;
        end
    end

    // Open-pin detect wins over the sensed level, which means nothing on a floating pin
    always_comb begin
        dcDecoded = LEVEL_A_40MV;
        if (levelAFloat) begin
            dcDecoded = LEVEL_A_60MV;
        end else if (levelAHigh) begin
            dcDecoded = LEVEL_A_80MV;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Settle counter: the synchronisers need two edges before the straps are valid
    logic [1:0] settle, next_settle;
    logic next_strapDone;
    logic captureNow;

    assign captureNow = !strapDone && (settle == STRAP_SETTLE);

    always_comb begin
        next_settle = settle;
        next_strapDone = strapDone;
        if (!strapDone && settle != STRAP_SETTLE) begin
            next_settle = settle + 2'h1;
        end
        if (captureNow) begin
            next_strapDone = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            settle <= 2'h0;
            strapDone <= 1'b0;
        end else begin
            settle <= next_settle;
            strapDone <= next_strapDone;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Strap results, loaded once per reset (level_a setting only outside I2C mode) and then frozen
    logic [1:0] next_acBoostSetting;
    hcsd_level_a_t next_dcBoostSetting;
    logic next_i2cMode;

    always_comb begin
        next_acBoostSetting = acBoostSetting;
        next_dcBoostSetting = dcBoostSetting;
        next_i2cMode = i2cMode;
        if (captureNow) begin
            next_i2cMode = i2cLinesUp;
            next_acBoostSetting = acDecoded;
            if (!i2cLinesUp) begin
                next_dcBoostSetting = dcDecoded;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            acBoostSetting <= AC_BOOST_MAX;
            dcBoostSetting <= LEVEL_A_60MV;
            i2cMode <= 1'b0;
        end else begin
            acBoostSetting <= next_acBoostSetting;
            dcBoostSetting <= next_dcBoostSetting;
            i2cMode <= next_i2cMode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Chirp timer
    hcsd_chirp_if chp ();

    hcsd_chirp_timer #(
        .MIN_CYC(CHIRP_MIN_CYC),
        .MAX_CYC(CHIRP_MAX_CYC),
        .CNT_W(CHIRP_CNT_W)
    ) u_chirp_timer (
        .mclk(mclk),
        .arst_n(arst_n),
        .chp(chp)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronised line events by name
    logic evPullup;
    logic evDisconnect;
    logic evBusReset;
    logic evSquelch;
    logic evChirpJ;
    logic evChirpK;
    logic evFixture;
    logic evTestPacket;

    assign evPullup = syncIn[B_PULLUP];
    assign evDisconnect = syncIn[B_DISC];
    assign evBusReset = syncIn[B_BUSRST];
    assign evSquelch = syncIn[B_SQUELCH];
    assign evChirpJ = syncIn[B_CHIRPJ];
    assign evChirpK = syncIn[B_CHIRPK];
    assign evFixture = syncIn[B_FIXTURE];
    assign evTestPacket = syncIn[B_TESTPKT];

    ////////////////////////////////////////////////////////////////////////////////
    // Link tracking
    hcsd_link_t link, next_link;
    logic running;
    logic disc;

    // Line events are ignored until the straps are in
    assign running = strapDone;
    assign disc = evDisconnect;
    assign chp.chirpJ = evChirpJ;
    assign chp.chirpK = evChirpK;
    assign chp.start = running && (link == LNK_CONN) && evBusReset;
    assign chp.abort = disc || (link != LNK_HSHAKE && link != LNK_CONN);

    always_comb begin
        next_link = link;
        if (running) begin
            unique case (link)
                LNK_UNCONN: begin
                    if (evFixture) begin
                        next_link = LNK_FIXTURE;
                    end else if (evPullup) begin
                        next_link = LNK_CONN;
                    end
                end
                LNK_FIXTURE: begin
                    if (evTestPacket) begin
                        next_link = LNK_HS;
                    end
                end
                LNK_CONN: begin
                    if (evBusReset) begin
                        next_link = LNK_HSHAKE;
                    end
                end
                LNK_HSHAKE: begin
                    if (chp.pass) begin
                        next_link = LNK_SQWAIT;
                    end else if (chp.fail) begin
                        next_link = LNK_CONN;
                    end
                end
                LNK_SQWAIT: begin
                    if (evSquelch) begin
                        next_link = LNK_HS;
                    end
                end
                // Further bus resets are ignored once in high speed
                LNK_HS: begin
                    next_link = LNK_HS;
                end
                default: begin
                    next_link = LNK_UNCONN;
                end
            endcase
            if (disc) begin
                next_link = LNK_UNCONN;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            link <= LNK_UNCONN;
        end else begin
            link <= next_link;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // High-speed and connect flags
    logic hsRaise;
    logic cdRaise;
    logic flagDrop;
    logic next_hsModeFlag;
    logic next_connectDetectFlag;

    assign hsRaise = running && ((link == LNK_FIXTURE && evTestPacket)
                                 || (link == LNK_SQWAIT && evSquelch));
    assign cdRaise = running && (link == LNK_UNCONN) && !evFixture && evPullup;
    // Disconnect outranks every raising event in the same cycle
    assign flagDrop = running && disc;

    always_comb begin
        next_hsModeFlag = hsModeFlag;
        next_connectDetectFlag = connectDetectFlag;
        if (hsRaise) begin
            next_hsModeFlag = 1'b1;
        end
        if (cdRaise) begin
            next_connectDetectFlag = 1'b1;
        end
        if (flagDrop) begin
            next_hsModeFlag = 1'b0;
            next_connectDetectFlag = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hsModeFlag <= 1'b0;
            connectDetectFlag <= 1'b0;
        end else begin
            hsModeFlag <= next_hsModeFlag;
            connectDetectFlag <= next_connectDetectFlag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drivers
    assign levelAOe = strapDone && !i2cMode;
    assign levelAOut = hsModeFlag;
    assign connectDetectOe = strapDone && !i2cMode;
    assign connectDetectOut = connectDetectFlag;
endmodule // hcsd_strap_detect

// ==== hcsd_strap_detect_props.sv ====
// Purpose: Concurrent checks on the ports of the strap and flag block
// Assumes: Single mclk domain, arst_n active low
// Notes: Event inputs are held at least four cycles by the bench
`timescale 1ns/1ps
module hcsd_strap_detect_props
    import hcsd_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [1:0] acBoostCode,
    input wire logic acBoostOpen,
    input wire logic levelAIn,
    input wire logic levelAOpen,
    input wire logic levelAOut,
    input wire logic levelAOe,
    input wire logic sdaIn,
    input wire logic sclIn,
    input wire logic connectDetectOut,
    input wire logic connectDetectOe,
    input wire logic pullupSeen,
    input wire logic disconnectSeen,
    input wire logic busResetSeen,
    input wire logic squelchSeen,
    input wire logic chirpJSeen,
    input wire logic chirpKSeen,
    input wire logic fixtureSeen,
    input wire logic testPacketSeen,
    input wire logic [1:0] acBoostSetting,
    input hcsd_pkg::hcsd_level_a_t dcBoostSetting,
    input wire logic i2cMode,
    input wire logic strapDone,
    input wire logic hsModeFlag,
    input wire logic connectDetectFlag
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////
    sequence sSettle;
        !strapDone [*3];
    endsequence
    sequence sCapture;
        sSettle ##1 strapDone;
    endsequence
    sequence sDrop;
        $rose(disconnectSeen) ##1 disconnectSeen;
    endsequence
    ////////////////////////////////////////////////////////////////
    AST_STRAP_TIME: assert property ($rose(arst_n) |-> sCapture)
        else $error("strap capture not at third edge");
    AST_STRAP_HOLD: assert property (strapDone && $past(strapDone) |->
        $stable(acBoostSetting) && $stable(dcBoostSetting) && $stable(i2cMode))
        else $error("strap result changed after capture");
    AST_NO_EARLY: assert property (!strapDone |-> !levelAOe && !connectDetectOe)
        else $error("pin driven before capture");
    AST_LA_DRIVE: assert property (levelAOe == (strapDone && !i2cMode) && levelAOut == hsModeFlag)
        else $error("level pin drive wrong");
    AST_I2C_QUIET: assert property (i2cMode |-> !levelAOe && !connectDetectOe
        && dcBoostSetting == LEVEL_A_60MV)
        else $error("pin used in serial mode");
    AST_CD_DRIVE: assert property (connectDetectOut == connectDetectFlag
        && connectDetectOe == (strapDone && !i2cMode))
        else $error("connect pin drive wrong");
    AST_CD_CAUSE: assert property ($rose(connectDetectFlag) |-> $past(pullupSeen, 2))
        else $error("connect flag without pull-up");
    AST_HS_CAUSE: assert property ($rose(hsModeFlag) |-> $past(squelchSeen, 2) || $past(testPacketSeen, 2))
        else $error("hs flag without cause");
    AST_HS_KEEP: assert property ($fell(hsModeFlag) |-> $past(disconnectSeen, 2))
        else $error("hs flag fell without disconnect");
    AST_DROP: assert property (sDrop |-> ##[1:4] !hsModeFlag && !connectDetectFlag)
        else $error("flags not cleared on disconnect");
endmodule // hcsd_strap_detect_props

bind hcsd_strap_detect hcsd_strap_detect_props i_props (.mclk(mclk), .arst_n(arst_n),
    .acBoostCode(acBoostCode), .acBoostOpen(acBoostOpen), .levelAIn(levelAIn), .levelAOpen(levelAOpen),
    .levelAOut(levelAOut), .levelAOe(levelAOe), .sdaIn(sdaIn), .sclIn(sclIn),
    .connectDetectOut(connectDetectOut), .connectDetectOe(connectDetectOe), .pullupSeen(pullupSeen),
    .disconnectSeen(disconnectSeen), .busResetSeen(busResetSeen), .squelchSeen(squelchSeen),
    .chirpJSeen(chirpJSeen), .chirpKSeen(chirpKSeen), .fixtureSeen(fixtureSeen),
    .testPacketSeen(testPacketSeen), .acBoostSetting(acBoostSetting), .dcBoostSetting(dcBoostSetting),
    .i2cMode(i2cMode), .strapDone(strapDone), .hsModeFlag(hsModeFlag), .connectDetectFlag(connectDetectFlag));

// ==== hcsd_link_model.sv ====
// Purpose: Host and attached device as seen by the line detectors
// Assumes: Events are levels held a number of mclk cycles
// Notes: ev bits 0 pullup 1 disconnect 2 bus reset 3 squelch 4 J 5 K 6 fixture 7 test packet
`timescale 1ns/1ps
module hcsd_link_model (
    input wire logic mclk,
    output logic [7:0] ev
);
    initial ev = 8'h00;
    // Raise one event for n cycles, then leave a quiet gap
    task automatic send(input int idx, input int n);
        @(posedge mclk);
        ev[idx] <= 1'b1;
        repeat (n) @(posedge mclk);
        ev[idx] <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    // Bus reset, then one J and one K of the given lengths
    task automatic handshake(input int jLen, input int kLen);
        send(2, 4);
        send(4, jLen);
        send(5, kLen);
    endtask
endmodule // hcsd_link_model

// ==== tb_hs_conditioner_strap_detect.sv ====
// Purpose: Self-checking bench of the strap and flag block
// Assumes: mclk 10 MHz, chirp bounds 180 and 1280 cycles
// Notes: Link events come from hcsd_link_model
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
module tb_hs_conditioner_strap_detect;
    import hcsd_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [1:0] acBoostCode = 2'h0;
    logic acBoostOpen = 1'b0;
    logic levelAIn = 1'b0;
    logic levelAOpen = 1'b0;
    logic sdaIn = 1'b0;
    logic sclIn = 1'b0;
    logic [7:0] ev;
    logic levelAOut, levelAOe, connectDetectOut, connectDetectOe;
    logic [1:0] acBoostSetting;
    hcsd_level_a_t dcBoostSetting;
    logic i2cMode, strapDone, hsModeFlag, connectDetectFlag;
    int fails = 0;
    int total_checks = 0;
    always #50 mclk = ~mclk;
    hcsd_link_model i_link (.mclk(mclk), .ev(ev));
    hcsd_strap_detect i_dut (.mclk(mclk), .arst_n(arst_n), .acBoostCode(acBoostCode),
        .acBoostOpen(acBoostOpen), .levelAIn(levelAIn), .levelAOpen(levelAOpen), .levelAOut(levelAOut),
        .levelAOe(levelAOe), .sdaIn(sdaIn), .sclIn(sclIn), .connectDetectOut(connectDetectOut),
        .connectDetectOe(connectDetectOe), .pullupSeen(ev[0]), .disconnectSeen(ev[1]),
        .busResetSeen(ev[2]), .squelchSeen(ev[3]), .chirpJSeen(ev[4]), .chirpKSeen(ev[5]),
        .fixtureSeen(ev[6]), .testPacketSeen(ev[7]), .acBoostSetting(acBoostSetting),
        .dcBoostSetting(dcBoostSetting), .i2cMode(i2cMode), .strapDone(strapDone),
        .hsModeFlag(hsModeFlag), .connectDetectFlag(connectDetectFlag));
    ////////////////////////////////////////////////////////////////
    task automatic strap(input logic [1:0] code, input logic aOpen, lIn, lOpen, sda, scl);
        @(posedge mclk);
        arst_n <= 1'b0;
        acBoostCode <= code;
        acBoostOpen <= aOpen;
        levelAIn <= lIn;
        levelAOpen <= lOpen;
        sdaIn <= sda;
        sclIn <= scl;
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (6) @(posedge mclk);
        #1;
    endtask
    task automatic final_report;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_straps;
        for (int i = 0; i < 4; i++) begin
            strap(i[1:0], 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
            `CHK(acBoostSetting, i[1:0])
            `CHK(dcBoostSetting, LEVEL_A_80MV)
            @(posedge mclk);
            acBoostCode <= ~i[1:0];
            levelAIn <= 1'b0;
            repeat (8) @(posedge mclk);
            #1;
            `CHK(acBoostSetting, i[1:0])
            `CHK(dcBoostSetting, LEVEL_A_80MV)
        end
        strap(2'h1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        `CHK(acBoostSetting, 2'h3)
        `CHK(dcBoostSetting, LEVEL_A_40MV)
        strap(2'h1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        `CHK(dcBoostSetting, LEVEL_A_60MV)
        `CHK(levelAOe, 1'b1)
        $display("t_straps done");
    endtask
    task automatic t_i2c;
        strap(2'h2, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        `CHK(i2cMode, 1'b1)
        `CHK(dcBoostSetting, LEVEL_A_60MV)
        i_link.send(0, 4);
        i_link.handshake(200, 200);
        i_link.send(3, 4);
        `CHK(levelAOe, 1'b0)
        `CHK(connectDetectOe, 1'b0)
        strap(2'h2, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        `CHK(i2cMode, 1'b0)
        $display("t_i2c done");
    endtask
    task automatic t_hs;
        strap(2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        i_link.send(0, 4);
        `CHK(connectDetectOut, 1'b1)
        i_link.send(7, 4);
        `CHK(hsModeFlag, 1'b0)
        i_link.handshake(180, 1280);
        i_link.send(3, 4);
        `CHK(levelAOut, 1'b1)
        i_link.send(1, 4);
        `CHK({hsModeFlag, connectDetectFlag}, 2'h0)
        i_link.send(6, 4);
        i_link.send(7, 4);
        `CHK(hsModeFlag, 1'b1)
        strap(2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        `CHK(hsModeFlag, 1'b0)
        $display("t_hs done");
    endtask
    task automatic t_chirp;
        strap(2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        i_link.send(0, 4);
        i_link.handshake(179, 200);
        i_link.send(3, 4);
        `CHK(hsModeFlag, 1'b0)
        i_link.handshake(200, 1281);
        i_link.send(3, 4);
        `CHK(hsModeFlag, 1'b0)
        i_link.handshake(1280, 180);
        i_link.send(3, 4);
        `CHK(hsModeFlag, 1'b1)
        $display("t_chirp done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        t_straps;
        t_i2c;
        t_hs;
        t_chirp;
        final_report;
    end
    // Watchdog against a hung sequence
    initial begin
        repeat (100000) @(posedge mclk);
        fails++;
        final_report;
    end
endmodule // tb_hs_conditioner_strap_detect
